// [sar_adc_conversion_sequencer.sv]
// Conversion sequencer of a successive-approximation converter with serial result output.
`timescale 1ns/1ps

package sar_seq_pkg;
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int CONV_HS_NS = 5000;
  localparam int CONV_AS_NS = 10000;
  localparam int ACQ_NS = 350;
  localparam int QUIET_NS = 250;
  localparam int THROUGHPUT_NS = 6250;
  localparam int CONV_HS_CYCLES = CONV_HS_NS / CLOCK_PERIOD_NS;
  localparam int CONV_AS_CYCLES = CONV_AS_NS / CLOCK_PERIOD_NS;
  localparam int ACQ_CYCLES = (ACQ_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int QUIET_CYCLES = (QUIET_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int THROUGHPUT_CYCLES = THROUGHPUT_NS / CLOCK_PERIOD_NS;
  localparam int CNT_W = 9;
  localparam int RESULT_BITS = 14;
  localparam int FRAME_BITS = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int BITCNT_W = 5;
  localparam logic [1:0] LEAD_ZEROS = 2'h0;
  localparam logic [FRAME_BITS-1:0] SHIFT_RESET = 16'h0000;
  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONVERT = 2'b01,
    ST_SLEEP = 2'b10
  } seq_state_type;
endpackage

module sar_adc_conversion_sequencer #(
  parameter int RESULT_W = sar_seq_pkg::RESULT_BITS,
  parameter int DEPTH = sar_seq_pkg::FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic conversion_start_n,
  input wire logic auto_sleep_mode,
  input wire logic serial_clock,
  input wire logic [RESULT_W-1:0] sample_code,
  output logic busy,
  output logic hold,
  output logic power_down,
  output logic buffer_full,
  output logic serial_result_out,
  output logic serial_result_oe
);
  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  logic cs_s1_ff;
  logic cs_s2_ff;
  logic cs_prev_ff;
  logic sck_s1_ff;
  logic sck_s2_ff;
  logic sck_prev_ff;
  logic mode_s1_ff;
  logic mode_s2_ff;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_s1_ff <= 1'b1;
      cs_s2_ff <= 1'b1;
      cs_prev_ff <= 1'b1;
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_prev_ff <= 1'b0;
      mode_s1_ff <= 1'b0;
      mode_s2_ff <= 1'b0;
    end else if (clk_en) begin
      cs_s1_ff <= conversion_start_n;
      cs_s2_ff <= cs_s1_ff;
      cs_prev_ff <= cs_s2_ff;
      sck_s1_ff <= serial_clock;
      sck_s2_ff <= sck_s1_ff;
      sck_prev_ff <= sck_s2_ff;
      mode_s1_ff <= auto_sleep_mode;
      mode_s2_ff <= mode_s1_ff;
    end
  end

  assign cs_fall = cs_prev_ff && !cs_s2_ff;
  assign cs_rise = !cs_prev_ff && cs_s2_ff;
  assign sck_fall = sck_prev_ff && !sck_s2_ff;

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  sar_seq_pkg::seq_state_type state_ff;
  logic [sar_seq_pkg::CNT_W-1:0] conv_cnt_ff;
  logic mode_ff;
  logic busy_ff;
  logic hold_ff;
  logic power_down_ff;
  logic full_ff;
  logic fifo_in_ready;
  logic start_ok;
  logic conv_end;
  logic push_ff;
  logic [RESULT_W-1:0] push_data_ff;

  // A full buffer refuses the start, so no finished result is dropped at the buffer input, except after a start taken in the cycle the previous result is pushed.
  assign start_ok = cs_fall && (state_ff != sar_seq_pkg::ST_CONVERT) && fifo_in_ready;
  assign conv_end = (state_ff == sar_seq_pkg::ST_CONVERT) && (conv_cnt_ff == '0);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= sar_seq_pkg::ST_TRACK;
      conv_cnt_ff <= '0;
      mode_ff <= 1'b0;
    end else if (clk_en) begin
      case (state_ff)
        sar_seq_pkg::ST_TRACK, sar_seq_pkg::ST_SLEEP: begin
          if (start_ok) begin
            state_ff <= sar_seq_pkg::ST_CONVERT;
            mode_ff <= mode_s2_ff;
            conv_cnt_ff <= mode_s2_ff ?
              sar_seq_pkg::CNT_W'(sar_seq_pkg::CONV_AS_CYCLES - 1) :
              sar_seq_pkg::CNT_W'(sar_seq_pkg::CONV_HS_CYCLES - 1);
          end else if (state_ff == sar_seq_pkg::ST_SLEEP && cs_rise) begin
            state_ff <= sar_seq_pkg::ST_TRACK;
          end
        end
        sar_seq_pkg::ST_CONVERT: begin
          if (conv_cnt_ff == '0) begin
            state_ff <= (mode_ff || !cs_s2_ff) ?
              sar_seq_pkg::ST_SLEEP : sar_seq_pkg::ST_TRACK;
          end else begin
            conv_cnt_ff <= conv_cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= sar_seq_pkg::ST_TRACK;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else if (clk_en) begin
      if (start_ok) begin
        busy_ff <= 1'b1;
        hold_ff <= 1'b1;
      end else if (conv_end) begin
        busy_ff <= 1'b0;
        hold_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      power_down_ff <= 1'b0;
    end else if (clk_en) begin
      if (conv_end) begin
        power_down_ff <= mode_ff || !cs_s2_ff;
      end else if (start_ok || cs_rise) begin
        power_down_ff <= 1'b0;
      end
    end
  end

  // The result is taken when the conversion completes and queued for the serial unit.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      push_ff <= 1'b0;
      push_data_ff <= '0;
      full_ff <= 1'b0;
    end else if (clk_en) begin
      push_ff <= conv_end;
      if (conv_end) begin
        push_data_ff <= sample_code;
      end
      full_ff <= !fifo_in_ready;
    end
  end

  // ************************************************************
  // Result buffer and serial output shifter
  // ************************************************************
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [RESULT_W-1:0] fifo_out_data;
  logic [sar_seq_pkg::FRAME_BITS-1:0] shift_ff;
  logic [sar_seq_pkg::BITCNT_W-1:0] bits_left_ff;
  logic oe_ff;
  logic sdo_ff;
  logic load;

  result_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .in_data(push_data_ff),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // The shifter drains the buffer only while idle, which is what stalls it.
  assign fifo_out_ready = !oe_ff && !cs_fall;
  assign load = fifo_out_valid && fifo_out_ready;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_ff <= sar_seq_pkg::SHIFT_RESET;
      bits_left_ff <= '0;
      oe_ff <= 1'b0;
      sdo_ff <= 1'b0;
    end else if (clk_en) begin
      if (cs_fall) begin
        shift_ff <= sar_seq_pkg::SHIFT_RESET;
        bits_left_ff <= '0;
        oe_ff <= 1'b0;
        sdo_ff <= 1'b0;
      end else if (load) begin
        shift_ff <= {sar_seq_pkg::LEAD_ZEROS, fifo_out_data};
        bits_left_ff <= sar_seq_pkg::BITCNT_W'(sar_seq_pkg::FRAME_BITS);
        oe_ff <= 1'b1;
        sdo_ff <= sar_seq_pkg::LEAD_ZEROS[1];
      end else if (oe_ff && sck_fall) begin
        bits_left_ff <= bits_left_ff - 1'b1;
        if (bits_left_ff == 5'h01) begin
          oe_ff <= 1'b0;
          sdo_ff <= 1'b0;
        end else begin
          shift_ff <= {shift_ff[sar_seq_pkg::FRAME_BITS-2:0], 1'b0};
          sdo_ff <= shift_ff[sar_seq_pkg::FRAME_BITS-2];
        end
      end
    end
  end

  assign busy = busy_ff;
  assign hold = hold_ff;
  assign power_down = power_down_ff;
  assign buffer_full = full_ff;
  assign serial_result_out = sdo_ff;
  assign serial_result_oe = oe_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  logic [sar_seq_pkg::CNT_W-1:0] busy_len_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_len_ff <= '0;
    end else if (clk_en) begin
      busy_len_ff <= busy_ff ? busy_len_ff + 1'b1 : '0;
    end
  end

  a_busy_on_start: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    start_ok |=> busy_ff && hold_ff)
    else $error("busy or hold did not rise after a start");
  a_conv_time_fast: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    $fell(busy_ff) && !mode_ff |-> busy_len_ff == 9'(sar_seq_pkg::CONV_HS_CYCLES))
    else $error("high-sampling conversion length wrong");
  a_conv_time_sleep: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    $fell(busy_ff) && mode_ff |-> busy_len_ff == 9'(sar_seq_pkg::CONV_AS_CYCLES))
    else $error("auto-sleep conversion length wrong");
  a_track_at_end: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    hold_ff == busy_ff)
    else $error("track/hold not following the conversion");
  a_no_restart: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    busy_ff && cs_fall && conv_cnt_ff != '0 |=> conv_cnt_ff == $past(conv_cnt_ff) - 1'b1)
    else $error("conversion restarted while busy");
  a_sleep_at_end: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    conv_end && (mode_ff || !cs_s2_ff) |=> power_down_ff ##0 !busy_ff)
    else $error("no power-down at conversion end");
  a_frame_lead: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    load && !cs_fall |=> oe_ff && !sdo_ff && bits_left_ff == 5'h10)
    else $error("frame does not open with a leading zero");
  a_frame_float: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    oe_ff && sck_fall && bits_left_ff == 5'h01 && !cs_fall |=> !oe_ff)
    else $error("output still driven after sixteen bits");
  a_shift_reset: assert property (@(posedge clock iff clk_en) disable iff (!rst_n)
    cs_fall |=> !oe_ff && shift_ff == sar_seq_pkg::SHIFT_RESET)
    else $error("shift register not reset by a start");

  c_fast_conv: cover property (@(posedge clock iff clk_en) disable iff (!rst_n)
    $fell(busy_ff) && !mode_ff);
  c_sleep_wake: cover property (@(posedge clock iff clk_en) disable iff (!rst_n)
    state_ff == sar_seq_pkg::ST_SLEEP && cs_rise);
  c_full_frame: cover property (@(posedge clock iff clk_en) disable iff (!rst_n)
    oe_ff && sck_fall && bits_left_ff == 5'h01);
  c_buffer_full: cover property (@(posedge clock iff clk_en) disable iff (!rst_n)
    full_ff);
endmodule

// [result_fifo.sv]
// Synchronous FIFO with a registered output word, used as the result buffer.
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic out_valid_ff;
  logic push;
  logic pop;
  logic refill;
  logic mem_read;
  logic bypass;
  logic mem_write;

  assign in_ready = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign push = in_valid && in_ready;
  assign pop = out_valid_ff && out_ready;
  assign refill = !out_valid_ff || pop;
  assign mem_read = refill && (count_ff != '0);
  // A word arriving at an empty FIFO goes straight to the output register.
  assign bypass = refill && (count_ff == '0) && push;
  assign mem_write = push && !bypass;

  always_ff @(posedge clock) begin
    if (clk_en && mem_write) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else if (clk_en) begin
      if (mem_write) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (mem_read) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (mem_write && !mem_read) begin
        count_ff <= count_ff + 1'b1;
      end else if (!mem_write && mem_read) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else if (clk_en) begin
      if (mem_read) begin
        out_valid_ff <= 1'b1;
        out_data_ff <= mem_ff[rd_ptr_ff];
      end else if (bypass) begin
        out_valid_ff <= 1'b1;
        out_data_ff <= in_data;
      end else if (pop) begin
        out_valid_ff <= 1'b0;
      end
    end
  end
endmodule

// [host_model.sv]
// Host-side model that issues conversion starts and clocks result frames out of the block.
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  output logic conversion_start_n,
  output logic serial_clock
);
  initial begin
    conversion_start_n = 1'b1;
    serial_clock = 1'b0;
  end

  // The quiet gap before each start also covers acquisition after the previous end.
  task automatic start_pulse(input int low_cyc, input int gap_cyc, input int falls);
    repeat (10) @(posedge clock);
    for (int i = 0; i < falls; i++) begin
      conversion_start_n <= 1'b0;
      repeat (low_cyc) @(posedge clock);
      conversion_start_n <= 1'b1;
      if (i < falls - 1) repeat (gap_cyc) @(posedge clock);
    end
  endtask

  // The serial clock runs only inside a frame and is left low afterwards.
  // Each bit is read late in the high phase, well after the block has moved the pin.
  task automatic read_frame(input int bits, output logic [15:0] word, output bit ok);
    word = 16'h0000;
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clock);
      ok = (serial_result_oe === 1'b1);
    end
    for (int k = 0; k < bits && ok; k++) begin
      serial_clock <= 1'b1;
      repeat (4) @(posedge clock);
      word = {word[14:0], serial_result_out};
      serial_clock <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
endmodule

// [test_sar_adc_conversion_sequencer.sv]
// Self-checking testbench of the conversion sequencer against a queue-based model.
`timescale 1ns/1ps
module test_sar_adc_conversion_sequencer;
  logic clock;
  logic rst_n;
  logic clk_en;
  logic auto_sleep_mode;
  logic [13:0] sample_code;
  logic conversion_start_n;
  logic serial_clock;
  logic busy;
  logic hold;
  logic power_down;
  logic buffer_full;
  logic serial_result_out;
  logic serial_result_oe;
  int n_errors = 0;
  int n_checks = 0;
  logic [13:0] expq[$];

  sar_adc_conversion_sequencer #(.RESULT_W(14), .DEPTH(16)) i_dut (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .conversion_start_n(conversion_start_n), .auto_sleep_mode(auto_sleep_mode),
    .serial_clock(serial_clock), .sample_code(sample_code), .busy(busy), .hold(hold),
    .power_down(power_down), .buffer_full(buffer_full),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe)
  );

  host_model i_host (
    .clock(clock), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .conversion_start_n(conversion_start_n),
    .serial_clock(serial_clock)
  );

  // ****************************************
  // Checking and closing tasks
  // ****************************************
  task automatic compare_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_flag(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Conversion and read sequences
  // ****************************************
  // A start fall while a frame is loaded discards that word, so the model drops it too.
  task automatic conv(input logic mode, input int low_cyc, input int falls);
    int len;
    bit seen;
    logic pd_exp;
    logic [13:0] code;
    code = 14'($urandom);
    auto_sleep_mode <= mode;
    sample_code <= code;
    if (serial_result_oe === 1'b1) void'(expq.pop_front());
    fork
      i_host.start_pulse(low_cyc, 50, falls);
      begin
        seen = 0;
        len = 0;
        for (int i = 0; i < 20 && !seen; i++) begin
          @(posedge clock);
          #1;
          seen = (busy === 1'b1);
        end
        compare_flag(seen, 1'b1);
        compare_flag(hold, 1'b1);
        compare_flag(serial_result_oe, 1'b0);
        while (seen && len < 400) begin
          len++;
          @(posedge clock);
          #1;
          seen = (busy === 1'b1);
        end
        compare_word(16'(len), mode ? 16'(sar_seq_pkg::CONV_AS_CYCLES) :
                     16'(sar_seq_pkg::CONV_HS_CYCLES));
        compare_flag(hold, 1'b0);
        pd_exp = mode | (conversion_start_n === 1'b0);
        compare_flag(power_down, pd_exp);
      end
    join
    expq.push_back(code);
    if (!mode && low_cyc > 130) begin
      repeat (16) @(posedge clock);
      compare_flag(power_down, 1'b0);
    end
  endtask

  task automatic read(input int bits);
    logic [15:0] w;
    bit ok;
    i_host.read_frame(bits, w, ok);
    if (!ok) begin
      n_errors++;
      complete_run();
    end
    if (bits == 16) begin
      compare_word(w, {2'b00, expq.pop_front()});
      repeat (4) @(posedge clock);
      compare_flag(serial_result_oe, 1'b0);
    end
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    complete_run();
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    auto_sleep_mode = 1'b0;
    sample_code = 14'h0000;
    void'($urandom(32'hF416));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    conv(1'b0, 200, 1);
    read(16);
    conv(1'b0, 2, 1);
    read(16);
    conv(1'b1, 2, 1);
    read(16);
    $display("Test modes and power-down done");
    conv(1'b0, 3, 2);
    read(16);
    $display("Test ignored restart done");
    conv(1'b1, 2, 1);
    read(5);
    conv(1'b0, 2, 1);
    read(16);
    $display("Test aborted read done");
    repeat (6) begin
      // Start lengths near the conversion end are skipped, where the pin sampling is ambiguous.
      conv(1'($urandom),
           ($urandom % 2) ? 2 + int'($urandom % 110) : 140 + int'($urandom % 60), 1);
      read(16);
    end
    compare_flag(buffer_full, 1'b0);
    $display("Test random conversions done");
    clk_en <= 1'b0;
    i_host.start_pulse(4, 3, 1);
    repeat (4) @(posedge clock);
    compare_flag(busy, 1'b0);
    clk_en <= 1'b1;
    repeat (8) @(posedge clock);
    compare_flag(busy, 1'b0);
    $display("Test clock enable freeze done");
    complete_run();
  end
endmodule
